// ---- scpxo_pkg.sv ----
// shared constants for the serial command port with software flow control
`default_nettype none
package scpxo_pkg;
  localparam int          CLK_HZ       = 40_000_000;
  localparam logic [7:0]  XOFF_CHAR    = 8'h13;
  localparam logic [7:0]  XON_CHAR     = 8'h11;
  localparam logic [7:0]  CR_CHAR      = 8'h0D;
  localparam logic [7:0]  LF_CHAR      = 8'h0A;
  localparam int          HIGH_PCT     = 75;
  localparam int          LOW_PCT      = 25;
  localparam int          DATA_BITS    = 8;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [1:0]  RATE_9600    = 2'h0;
  localparam logic [1:0]  RATE_19200   = 2'h1;
  localparam logic [1:0]  RATE_38400   = 2'h2;
  localparam logic [1:0]  RATE_57600   = 2'h3;
  localparam int          BAUD_9600    = 9600;
  localparam int          BAUD_19200   = 19200;
  localparam int          BAUD_38400   = 38400;
  localparam int          BAUD_57600   = 57600;
  // cycles per bit, rounded down
  localparam logic [15:0] DIV_9600     = 16'(CLK_HZ / BAUD_9600);
  localparam logic [15:0] DIV_19200    = 16'(CLK_HZ / BAUD_19200);
  localparam logic [15:0] DIV_38400    = 16'(CLK_HZ / BAUD_38400);
  localparam logic [15:0] DIV_57600    = 16'(CLK_HZ / BAUD_57600);
  localparam logic [3:0]  BIT_CNT_RST  = 4'h0;
  localparam logic [15:0] DIV_CNT_RST  = 16'h0000;
  localparam logic [7:0]  SHIFT_RST    = 8'h00;
  localparam logic [3:0]  FRAME_BITS   = 4'h9;
  localparam logic [3:0]  LAST_DATA    = 4'h8;

  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } scpxo_rx_e;
endpackage
`default_nettype wire

// ---- scpxo_fifo.sv ----
// parameterised synchronous fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module scpxo_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic [WIDTH-1:0]         inData,
  input  wire logic                     inValid,
  output logic                          inReady,
  output logic [WIDTH-1:0]              outData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic [$clog2(DEPTH+1)-1:0]    level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [$clog2(DEPTH+1)-1:0] count;
  logic             outFull;
  wire              pop   = outFull && outReady;
  wire              load  = (count != '0) && (!outFull || pop);
  wire              push  = inValid && inReady;
  wire [CW-1:0]     countOne = {{(CW-1){1'b0}}, 1'b1};

  assign inReady  = (count != CW'(DEPTH));
  assign outValid = outFull;
  assign level    = count + (outFull ? countOne : '0);

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      count   <= '0;
      outFull <= 1'b0;
      outData <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (load)
      begin
        outData <= mem[rdPtr];
        rdPtr   <= rdPtr + 1'b1;
      end
      count   <= count + (push ? countOne : '0) - (load ? countOne : '0);
      outFull <= load || (outFull && !pop);
    end
  end
endmodule
`default_nettype wire

// ---- scpxo_serial_port.sv ----
// full duplex serial command port with xon/xoff flow control
`timescale 1ns/1ps
`default_nettype none
// Operation
// - transmitter and receiver run at once, independently, asynchronous framing.
// - bit rate chosen from 9600, 19200, 38400 or 57600; ends must match.
// - flow control by in-band xon/xoff characters only; can be switched off.
// - receive buffer above 75 percent full sends xoff, 13h.
// - after xoff, buffer below 25 percent sends xon, 11h.
// - received xoff halts outgoing data characters; xon/xoff still go out.
// - received xon resumes halted transmission of pending characters.
// - message characters are ascii codes.
module scpxo_serial_port
#(
  parameter int DEPTH = scpxo_pkg::FIFO_DEPTH
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] rateSel,
  input  wire logic       flowEnable,
  input  wire logic       termCrOnly,
  input  wire logic       rxLine,
  output logic            txLine,
  output logic [7:0]      rxData,
  output logic            rxValid,
  input  wire logic       rxReady,
  output logic            rxEndOfMsg,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic       txEndOfMsg,
  output logic            txHalted,
  output logic            rxOverrun
);
  import scpxo_pkg::*;

  // ************************************************
  // bit rate
  // ************************************************
  function automatic logic [15:0] bitDiv(input logic [1:0] sel);
    case (sel)
      RATE_9600:  bitDiv = DIV_9600;
      RATE_19200: bitDiv = DIV_19200;
      RATE_38400: bitDiv = DIV_38400;
      default:    bitDiv = DIV_57600;
    endcase
  endfunction

  wire [15:0] divFull = bitDiv(rateSel);
  wire [15:0] divHalf = {1'b0, divFull[15:1]};

  // ************************************************
  // receiver
  // ************************************************
  scpxo_rx_e  rxState;
  logic [15:0] rxDiv;
  logic [3:0]  rxBits;
  logic [7:0]  rxShift;
  logic        rxSync1;
  logic        rxSync2;
  logic        rxWrite;
  logic        rxFifoReady;
  logic        lastCr;
  logic        xoffSent;
  logic        remoteHalt;
  logic        needXoff;
  logic        needXon;
  logic [$clog2(DEPTH+1)-1:0] rxLevel;
  logic [8:0]  rxFifoOut;

  wire rxTick   = (rxDiv == 16'h0000);
  wire isXon    = (rxShift == XON_CHAR);
  wire isXoff   = (rxShift == XOFF_CHAR);
  wire rxDone   = (rxState == RX_STOP) && rxTick && rxSync2;
  wire rxIsCtl  = flowEnable && (isXon || isXoff);
  wire rxStore  = rxDone && !rxIsCtl;
  // end of message: lf after cr, or cr alone when so selected
  wire rxEom    = termCrOnly ? (rxShift == CR_CHAR) : (lastCr && rxShift == LF_CHAR);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rxSync1 <= 1'b1;
      rxSync2 <= 1'b1;
    end
    else
    begin
      rxSync1 <= rxLine;
      rxSync2 <= rxSync1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rxState <= RX_IDLE;
      rxDiv   <= DIV_CNT_RST;
      rxBits  <= BIT_CNT_RST;
      rxShift <= SHIFT_RST;
    end
    else
    begin
      rxDiv <= rxTick ? divFull - 16'h0001 : rxDiv - 16'h0001;
      case (rxState)
        RX_IDLE:
          if (!rxSync2)
          begin
            rxState <= RX_START;
            rxDiv   <= divHalf;
          end
        RX_START:
          if (rxTick)
          begin
            rxState <= rxSync2 ? RX_IDLE : RX_DATA;
            rxBits  <= BIT_CNT_RST;
          end
        RX_DATA:
          if (rxTick)
          begin
            rxShift <= {rxSync2, rxShift[7:1]};
            rxBits  <= rxBits + 4'h1;
            if (rxBits == LAST_DATA - 4'h1)
              rxState <= RX_STOP;
          end
        RX_STOP:
          if (rxTick)
            rxState <= RX_IDLE;
        default:
          rxState <= RX_IDLE;
      endcase
    end
  end

  assign rxWrite = rxStore && rxFifoReady;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lastCr     <= 1'b0;
      remoteHalt <= 1'b0;
      rxOverrun  <= 1'b0;
    end
    else
    begin
      if (rxStore)
        lastCr <= (rxShift == CR_CHAR);
      if (!flowEnable)
        remoteHalt <= 1'b0;
      else if (rxDone && isXoff)
        remoteHalt <= 1'b1;
      else if (rxDone && isXon)
        remoteHalt <= 1'b0;
      if (rxStore && !rxFifoReady)
        rxOverrun <= 1'b1;
    end
  end

  scpxo_fifo #(.WIDTH(9), .DEPTH(DEPTH)) rxFifo
  (
    .clk      (clk),
    .reset    (reset),
    .inData   ({rxEom, rxShift}),
    .inValid  (rxWrite),
    .inReady  (rxFifoReady),
    .outData  (rxFifoOut),
    .outValid (rxValid),
    .outReady (rxReady),
    .level    (rxLevel)
  );

  assign rxData     = rxFifoOut[7:0];
  assign rxEndOfMsg = rxFifoOut[8];

  // ************************************************
  // flow thresholds
  // ************************************************
  wire [15:0] lvl100 = 16'(rxLevel) * 16'd100;
  wire aboveHigh     = lvl100 > 16'(DEPTH * HIGH_PCT);
  wire belowLow      = lvl100 < 16'(DEPTH * LOW_PCT);

  // ************************************************
  // transmitter
  // ************************************************
  logic [15:0] txDiv;
  logic [3:0]  txBits;
  logic [9:0]  txShift;
  logic        txBusy;
  logic [7:0]  txQData;
  logic        txQValid;
  logic        txQReady;
  logic        txTermPend;

  wire txTick    = (txDiv == 16'h0000);
  wire sendCtl   = !txBusy && (needXoff || needXon);
  wire sendData  = !txBusy && !sendCtl && txQValid && !remoteHalt && !txTermPend;
  wire sendLf    = !txBusy && !sendCtl && !remoteHalt && txTermPend;
  wire [7:0] ctlChar = needXoff ? XOFF_CHAR : XON_CHAR;
  wire [7:0] txChar  = sendCtl ? ctlChar : (sendLf ? LF_CHAR : txQData);
  wire txStart   = sendCtl || sendData || sendLf;

  assign txQReady = sendData;
  assign txHalted = remoteHalt;
  assign needXoff = flowEnable && !xoffSent && aboveHigh;
  assign needXon  = flowEnable && xoffSent && belowLow;

  scpxo_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo
  (
    .clk      (clk),
    .reset    (reset),
    .inData   (txEndOfMsg ? CR_CHAR : txData),
    .inValid  (txValid),
    .inReady  (txReady),
    .outData  (txQData),
    .outValid (txQValid),
    .outReady (txQReady),
    .level    ()
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      txDiv      <= DIV_CNT_RST;
      txBits     <= BIT_CNT_RST;
      txShift    <= 10'h3FF;
      txBusy     <= 1'b0;
      txLine     <= 1'b1;
      xoffSent   <= 1'b0;
      txTermPend <= 1'b0;
    end
    else
    begin
      if (!flowEnable)
        xoffSent <= 1'b0;
      else if (sendCtl)
        xoffSent <= needXoff;
      if (sendData)
        txTermPend <= !termCrOnly && (txQData == CR_CHAR);
      else if (sendLf)
        txTermPend <= 1'b0;
      if (txStart)
      begin
        txShift <= {1'b1, txChar, 1'b0};
        txBusy  <= 1'b1;
        txBits  <= BIT_CNT_RST;
        txDiv   <= divFull - 16'h0001;
        txLine  <= 1'b0;
      end
      else if (txBusy)
      begin
        txDiv <= txTick ? divFull - 16'h0001 : txDiv - 16'h0001;
        if (txTick)
        begin
          if (txBits == FRAME_BITS)
          begin
            txBusy <= 1'b0;
            txLine <= 1'b1;
          end
          else
          begin
            txLine <= txShift[txBits + 4'h1];
            txBits <= txBits + 4'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- scpxo_port_checker_assertions.sv ----
// concurrent checks on the serial command port pins
`timescale 1ns/1ps
`default_nettype none
module scpxo_port_checker
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [1:0] rateSel,
  input wire logic       flowEnable,
  input wire logic       txLine,
  input wire logic [7:0] rxData,
  input wire logic       rxValid,
  input wire logic       rxReady,
  input wire logic       txReady,
  input wire logic       txHalted,
  input wire logic       rxOverrun
);
  import scpxo_pkg::*;
  logic [15:0] div;
  logic [15:0] pos;
  logic        prevTx;
  assign div = (rateSel == RATE_9600) ? DIV_9600 : (rateSel == RATE_19200) ? DIV_19200 :
               (rateSel == RATE_38400) ? DIV_38400 : DIV_57600;
  // ****
  // position inside an outgoing frame
  // ****
  always_ff @(posedge clk)
  begin
    prevTx <= txLine;
    if (reset)
      pos <= 16'h0000;
    else if (pos != 16'h0000)
      pos <= (pos == 16'(10 * div - 1)) ? 16'h0000 : pos + 16'h0001;
    else if (prevTx && !txLine)
      pos <= 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  reset_idle_a: assert property ($fell(reset) |-> txLine && !rxValid && txReady)
    else $error("outputs not idle after reset");
  reset_flags_a: assert property (!reset && $past(reset) |-> !txHalted && !rxOverrun)
    else $error("flags set after reset");
  overrun_sticky_a: assert property (rxOverrun |=> rxOverrun)
    else $error("overrun flag dropped");
  valid_hold_a: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
    else $error("receive data not held");
  start_low_a: assert property (pos == (div >> 1) |-> !txLine)
    else $error("start bit not low");
  stop_high_a: assert property (pos == 16'(9 * div + (div >> 1)) |-> txLine)
    else $error("stop bit not high");
  bit_steady_a: assert property (pos != 0 && pos % div > 1 && pos % div < div - 2
    |=> $stable(txLine))
    else $error("line moved inside a bit");
  halt_flow_a: assert property ($rose(txHalted) |-> flowEnable)
    else $error("halt without flow control");
endmodule
bind scpxo_serial_port scpxo_port_checker chk (.clk, .reset, .rateSel, .flowEnable,
  .txLine, .rxData, .rxValid, .rxReady, .txReady, .txHalted, .rxOverrun);
`default_nettype wire

// ---- scpxo_host_model.sv ----
// behavioural host controller at the far end of the serial link
`timescale 1ns/1ps
`default_nettype none
module scpxo_host_model
(
  input  wire logic        clk,
  input  wire logic [15:0] div,
  input  wire logic        txLine,
  output var logic         rxLine
);
  logic [7:0] got [$];
  logic [7:0] b;
  initial rxLine = 1'b1;
  // ****
  // frame sender and independent receiver
  // ****
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxLine <= f[i];
      repeat (div) @(posedge clk);
    end
  endtask
  always
  begin
    @(posedge clk);
    if (txLine === 1'b0)
    begin
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (div) @(posedge clk);
        b[i] = txLine;
      end
      got.push_back(b);
      repeat (div) @(posedge clk);
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module tb;
  import scpxo_pkg::*;
  logic clk = 1'b0, reset = 1'b1, rxReady = 1'b0, txValid = 1'b0, txEom = 1'b0;
  logic flowEnable = 1'b1, termCrOnly = 1'b0;
  logic [7:0] txData = 8'h00, rxData, v [7];
  logic txLine, rxLine, rxValid, rxEom, txReady, txHalted, rxOverrun;
  int err_count = 0, total_checks = 0, seed;
  initial forever #12.5 clk = ~clk;
  scpxo_serial_port #(.DEPTH(8)) dut (.clk, .reset, .rateSel(RATE_57600),
    .flowEnable, .termCrOnly, .rxLine, .txLine, .rxData, .rxValid,
    .rxReady, .rxEndOfMsg(rxEom), .txData, .txValid, .txReady,
    .txEndOfMsg(txEom), .txHalted, .rxOverrun);
  scpxo_host_model host (.clk, .div(DIV_57600), .txLine, .rxLine);
  // ****
  // shared tasks
  // ****
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic push(input logic [7:0] d, input logic m);
    txData <= d;
    txEom <= m;
    txValid <= 1'b1;
    do @(posedge clk); while (txReady !== 1'b1);
    txValid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pop(input logic [7:0] e, input logic m);
    int n = 0;
    while (rxValid !== 1'b1 && n++ < 9000)
      @(posedge clk);
    `CHK(rxValid, 1'b1)
    `CHK(rxData, e)
    `CHK(rxEom, m)
    rxReady <= 1'b1;
    @(posedge clk);
    rxReady <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic expTx(input logic [7:0] e);
    int n = 0;
    logic [7:0] g;
    while (host.got.size() == 0 && n++ < 9000)
      @(posedge clk);
    g = (host.got.size() != 0) ? host.got.pop_front() : 8'hxx;
    `CHK(g, e)
  endtask
  // counts start bits on the outgoing line over n cycles
  task automatic quiet(input int n);
    int falls = 0;
    logic last;
    last = txLine;
    repeat (n)
    begin
      @(posedge clk);
      if (last === 1'b1 && txLine === 1'b0)
        falls++;
      last = txLine;
    end
    `CHK(falls, 0)
  endtask
  initial
  begin
    seed = $urandom(32'he9e1);
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({txLine, rxValid, txReady}, 3'b101)
    `CHK({txHalted, rxOverrun}, 2'b00)
    for (int i = 0; i < 7; i++)
      v[i] = 8'($urandom_range(32'h7e, 32'h20));
    v[5] = CR_CHAR;
    v[6] = LF_CHAR;
    for (int i = 0; i < 3; i++)
      push(v[i], 1'b0);
    push(8'h00, 1'b1);
    for (int i = 0; i < 7; i++)
      host.send(v[i]);
    for (int i = 0; i < 3; i++)
      expTx(v[i]);
    expTx(CR_CHAR);
    expTx(LF_CHAR);
    expTx(XOFF_CHAR);
    for (int i = 0; i < 7; i++)
      pop(v[i], i == 6);
    expTx(XON_CHAR);
    host.send(XOFF_CHAR);
    `CHK(txHalted, 1'b1)
    push(v[4], 1'b0);
    quiet(1500);
    `CHK(host.got.size(), 0)
    host.send(XON_CHAR);
    `CHK({txHalted, rxValid}, 2'b00)
    expTx(v[4]);
    // flow control off: xoff is plain data; cr alone ends a message
    flowEnable <= 1'b0;
    termCrOnly <= 1'b1;
    push(8'h00, 1'b1);
    host.send(XOFF_CHAR);
    `CHK(txHalted, 1'b0)
    pop(XOFF_CHAR, 1'b0);
    expTx(CR_CHAR);
    quiet(1500);
    `CHK(rxOverrun, 1'b0)
    end_of_test;
  end
  initial
  begin
    // clean run is about 90k cycles at the fastest rate
    repeat (96000) @(posedge clk);
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
